// File: inc/secarea_pkg.sv
// constants and types shared by the security area and page buffer command logic
`default_nettype none
package secarea_pkg;
	// opcodes and the fixed argument bytes of the security program sequence
	localparam logic [7:0] OP_SEC_PROG = 8'h9B;
	localparam logic [7:0] OP_SEC_READ = 8'h77;
	localparam logic [7:0] OP_XFER_B1 = 8'h53;
	localparam logic [7:0] OP_XFER_B2 = 8'h55;
	localparam logic [7:0] OP_CMP_B1 = 8'h60;
	localparam logic [7:0] OP_CMP_B2 = 8'h61;
	localparam logic [7:0] OP_STATUS = 8'hD7;
	localparam logic [7:0] SEC_PROG_ARG = 8'h00;
	localparam logic [7:0] UNDEF_BYTE = 8'h00;
	// sizes of the storage
	localparam int SEC_BYTES = 128;
	localparam int SEC_USER_BYTES = 64;
	localparam int SEC_PTR_W = 6;
	localparam int PAGE_COUNT = 2048;
	localparam int PAGE_BYTES_STD = 264;
	localparam int PAGE_BYTES_BIN = 256;
	localparam int PAGE_IDX_W = 11;
	localparam int HDR_BYTES = 4;
	// page index position inside the 24-bit address field
	localparam int STD_IDX_LSB = 9;
	localparam int BIN_IDX_LSB = 8;
	// status byte layout
	localparam int STAT_READY_BIT = 7;
	localparam int STAT_COMP_BIT = 6;
	localparam logic [3:0] STAT_DENSITY = 4'h7;
	localparam logic STAT_PROTECT = 1'b0;
	// self-timed durations and the cycle counts derived from them (longest times round down)
	localparam int CLK_PERIOD_NS = 40;
	localparam int SECW_TIME_NS = 200000;
	localparam int COPY_TIME_NS = 100000;
	localparam int CHECK_TIME_NS = 100000;
	localparam int SECW_CYCLES = SECW_TIME_NS / CLK_PERIOD_NS;
	localparam int COPY_CYCLES = COPY_TIME_NS / CLK_PERIOD_NS;
	localparam int CHECK_CYCLES = CHECK_TIME_NS / CLK_PERIOD_NS;
	// data fifo: pointer bits plus data byte
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_WIDTH = SEC_PTR_W + 8;
	typedef enum {OPS_IDLE, OPS_SECW, OPS_COPY, OPS_CHECK} op_state_e;
endpackage : secarea_pkg
`default_nettype wire

// File: src/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 32
) (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic [WIDTH-1:0] inData, // word to store
	input wire logic inValid, // producer offers a word
	output logic inReady, // room for a word
	output logic [WIDTH-1:0] outData, // oldest word
	output logic outValid, // a word is waiting
	input wire logic outReady // consumer takes the word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	logic pushFire;
	logic popFire;

	// full and empty from pointers with a wrap bit
	assign inReady = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
	assign outValid = (wrPtr_q != rdPtr_q);
	assign outData = mem[rdPtr_q[AW-1:0]];
	assign pushFire = inValid && inReady;
	assign popFire = outValid && outReady;

	// storage array
	always_ff @(posedge clk) begin
		if (pushFire) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end

	// pointers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (pushFire) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (popFire) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end
endmodule : byte_fifo
`default_nettype wire

// File: src/security_area_and_page_buffer_ops.sv
// serial command logic for the security area, page-to-buffer copy and page compare
//
// Contract
// - security area is 128 bytes: 0..63 user one-time part, 64..127 factory part.
// - once the user part is programmed, further programming is refused forever; the code clears its lock on reset.
// - locations 64..127 hold a fixed unique value no command can change.
// - user part programs without any erase step.
// - chip select rise after data starts timed security write; busy throughout.
// - bytes not supplied before chip select rises are left unspecified.
// - more than 64 data bytes wrap the pointer to location zero.
// - security programming uses buffer 1 as storage, overwriting it.
// - 77h plus three dummy bytes, then security bytes shift out.
// - after the last security byte, further clocks give undefined data.
// - chip select rise ends the read and floats the output.
// - 264-byte pages: four dummy bits, 11-bit page index, nine dummy bits.
// - 256-byte pages: five dummy bits, index from address bits 18..8, eight dummy.
// - chip select low during opcode and address; copy starts on its rise.
// - busy stays asserted for the whole copy time.
// - on chip select rise compare every page byte with buffer; busy meanwhile.
// - compare end writes the result into status bit 6, replacing the old one.
// - result bit reads 0 on match and 1 on any difference.
// - status bit 7 reads 0 while busy and 1 when ready.
// - D7h then status bytes stream every clock while chip select stays low; the code sends only the ready bit in every second byte.
`default_nettype none
module security_area_and_page_buffer_ops
	import secarea_pkg::*;
#(
	parameter int PAGES = secarea_pkg::PAGE_COUNT,
	parameter int PAGE_BYTES = secarea_pkg::PAGE_BYTES_STD,
	parameter int SECW_DUR = secarea_pkg::SECW_CYCLES,
	parameter int COPY_DUR = secarea_pkg::COPY_CYCLES,
	parameter int CHECK_DUR = secarea_pkg::CHECK_CYCLES,
	parameter logic [8*secarea_pkg::SEC_USER_BYTES-1:0] FACTORY_ID = {64{8'hA5}} // arbitrary value
) (
	input wire logic clk, // 25 MHz system clock
	input wire logic resetn, // async reset, active low
	input wire logic csn, // chip select pin, active low
	input wire logic sck, // serial clock pin
	input wire logic si, // serial data in pin
	output logic so, // serial data out
	output logic soOe, // serial out enable, high while driving
	input wire logic binaryPage, // page size strap: 1 selects 256-byte pages
	output logic readyOut, // high when no internal operation runs
	input wire logic loadEn, // main memory preload strobe
	input wire logic [$clog2(PAGES*PAGE_BYTES)-1:0] loadAddr, // preload byte address
	input wire logic [7:0] loadData // preload byte
);
	import secarea_pkg::*;
	localparam int MEM_AW = $clog2(PAGES*PAGE_BYTES);

	logic [7:0] mainMem [0:PAGES*PAGE_BYTES-1];
	logic [7:0] bufMem [0:1][0:PAGE_BYTES-1];
	logic [7:0] secUser [0:SEC_USER_BYTES-1];
	logic [2:0] csnS_q;
	logic [2:0] sckS_q;
	logic [1:0] siS_q;
	logic [1:0] binS_q;
	logic csHigh;
	logic csRise;
	logic sckRise;
	logic sckFall;
	logic byteDone;
	logic [7:0] rxByte;
	logic [2:0] bitCnt_q;
	logic [8:0] byteCnt_q;
	logic [6:0] shiftIn_q;
	logic [7:0] opcode_q;
	logic [23:0] addr_q;
	logic argOk_q;
	logic frameIgnore_q;
	logic [SEC_PTR_W-1:0] secPtr_q;
	logic [7:0] txByte;
	logic [8:0] secIdx;
	logic txActive;
	logic opBusy;
	logic pend_q;
	op_state_e pendKind_q;
	logic [PAGE_IDX_W-1:0] pendPage_q;
	logic pendBuf_q;
	op_state_e op_q;
	logic [PAGE_IDX_W-1:0] page_q;
	logic bufSel_q;
	logic [8:0] idx_q;
	logic [31:0] timer_q;
	logic walkDone_q;
	logic mismatch_q;
	logic compResult_q;
	logic otpLocked_q;
	logic [8:0] walkLast;
	logic [MEM_AW-1:0] memAddr;
	logic [FIFO_WIDTH-1:0] fifoOutData;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoPush;
	logic drainReady;
	logic [PAGE_IDX_W-1:0] rxPage;
	logic [7:0] statusByte;

	// two-flop synchronisers for every pin; third stage only for edge finding
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			csnS_q <= 3'h7;
			sckS_q <= 3'h0;
			siS_q <= 2'h0;
			binS_q <= 2'h0;
		end else begin
			csnS_q <= {csnS_q[1:0], csn};
			sckS_q <= {sckS_q[1:0], sck};
			siS_q <= {siS_q[0], si};
			binS_q <= {binS_q[0], binaryPage};
		end
	end

	// edges of the synchronised pins
	assign csHigh = csnS_q[1];
	assign csRise = csnS_q[1] && !csnS_q[2];
	assign sckRise = sckS_q[1] && !sckS_q[2];
	assign sckFall = !sckS_q[1] && sckS_q[2];
	assign rxByte = {shiftIn_q, siS_q[1]};
	assign byteDone = !csHigh && sckRise && (bitCnt_q == 3'h7);
	assign opBusy = pend_q || (op_q != OPS_IDLE);

	// bit and byte counters of the current frame, msb first
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bitCnt_q <= 3'h0;
			byteCnt_q <= 9'h000;
			shiftIn_q <= 7'h00;
		end else if (csHigh) begin
			bitCnt_q <= 3'h0;
			byteCnt_q <= 9'h000;
		end else if (sckRise) begin
			shiftIn_q <= rxByte[6:0];
			bitCnt_q <= bitCnt_q + 3'h1;
			if (bitCnt_q == 3'h7 && byteCnt_q != 9'h1FF) begin
				byteCnt_q <= byteCnt_q + 9'h001;
			end
		end
	end

	// opcode, address bytes and argument checks
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			opcode_q <= 8'h00;
			addr_q <= 24'h000000;
			argOk_q <= 1'b0;
			frameIgnore_q <= 1'b0;
		end else if (byteDone) begin
			if (byteCnt_q == 9'h000) begin
				opcode_q <= rxByte;
				argOk_q <= 1'b1;
				frameIgnore_q <= opBusy && (rxByte != OP_STATUS);
			end else if (byteCnt_q < 9'(HDR_BYTES)) begin
				addr_q <= {addr_q[15:0], rxByte};
				if (rxByte != SEC_PROG_ARG) begin
					argOk_q <= 1'b0;
				end
			end
		end
	end

	// data byte pointer for security programming, wraps modulo 64
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			secPtr_q <= '0;
		end else if (byteDone && byteCnt_q == 9'h000) begin
			secPtr_q <= '0;
		end else if (fifoPush) begin
			secPtr_q <= secPtr_q + 1'b1;
		end
	end

	// security data bytes are queued toward buffer 1
	assign fifoPush = byteDone && (byteCnt_q >= 9'(HDR_BYTES)) && (opcode_q == OP_SEC_PROG)
		&& argOk_q && !frameIgnore_q && fifoInReady;
	assign drainReady = (op_q == OPS_IDLE);

	byte_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_data_fifo (
		.clk(clk),
		.resetn(resetn),
		.inData({secPtr_q, rxByte}),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.outData(fifoOutData),
		.outValid(fifoOutValid),
		.outReady(drainReady)
	);

	// page index from the address field per page size
	assign rxPage = binS_q[1] ? addr_q[BIN_IDX_LSB +: PAGE_IDX_W] : addr_q[STD_IDX_LSB +: PAGE_IDX_W];

	// chip select rise turns a complete command into a pending operation
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pend_q <= 1'b0;
			pendKind_q <= OPS_IDLE;
			pendPage_q <= '0;
			pendBuf_q <= 1'b0;
		end else if (pend_q) begin
			if (!fifoOutValid && op_q == OPS_IDLE) begin
				pend_q <= 1'b0;
			end
		end else if (csRise && !frameIgnore_q && !opBusy && byteCnt_q >= 9'(HDR_BYTES)) begin
			pendPage_q <= rxPage;
			pendBuf_q <= (opcode_q == OP_XFER_B2) || (opcode_q == OP_CMP_B2);
			case (opcode_q)
				OP_SEC_PROG: begin
					if (argOk_q && byteCnt_q > 9'(HDR_BYTES)) begin
						pend_q <= 1'b1;
						pendKind_q <= OPS_SECW;
					end
				end
				OP_XFER_B1, OP_XFER_B2: begin
					pend_q <= 1'b1;
					pendKind_q <= OPS_COPY;
				end
				OP_CMP_B1, OP_CMP_B2: begin
					pend_q <= 1'b1;
					pendKind_q <= OPS_CHECK;
				end
				default: begin
					pend_q <= 1'b0;
				end
			endcase
		end
	end

	// length of the byte walk of the running operation
	always_comb begin
		if (op_q == OPS_SECW) begin
			walkLast = 9'(SEC_USER_BYTES - 1);
		end else if (binS_q[1]) begin
			walkLast = 9'(PAGE_BYTES_BIN - 1);
		end else begin
			walkLast = 9'(PAGE_BYTES - 1);
		end
	end
	assign memAddr = MEM_AW'(32'(page_q) * PAGE_BYTES + 32'(idx_q));

	// self-timed operation engine: byte walk plus duration timer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			op_q <= OPS_IDLE;
			page_q <= '0;
			bufSel_q <= 1'b0;
			idx_q <= 9'h000;
			timer_q <= 32'h00000000;
			walkDone_q <= 1'b0;
			mismatch_q <= 1'b0;
			compResult_q <= 1'b0;
			otpLocked_q <= 1'b0;
		end else begin
			case (op_q)
				OPS_IDLE: begin
					if (pend_q && !fifoOutValid) begin
						op_q <= pendKind_q;
						page_q <= pendPage_q;
						bufSel_q <= pendBuf_q;
						idx_q <= 9'h000;
						walkDone_q <= 1'b0;
						mismatch_q <= 1'b0;
						case (pendKind_q)
							OPS_SECW: timer_q <= 32'(SECW_DUR - 1);
							OPS_COPY: timer_q <= 32'(COPY_DUR - 1);
							default: timer_q <= 32'(CHECK_DUR - 1);
						endcase
					end
				end
				OPS_SECW, OPS_COPY, OPS_CHECK: begin
					if (timer_q != 32'h00000000) begin
						timer_q <= timer_q - 32'h00000001;
					end
					if (!walkDone_q) begin
						idx_q <= idx_q + 9'h001;
						walkDone_q <= (idx_q == walkLast);
						if (op_q == OPS_CHECK && mainMem[memAddr] != bufMem[bufSel_q][idx_q]) begin
							mismatch_q <= 1'b1;
						end
					end else if (timer_q == 32'h00000000) begin
						op_q <= OPS_IDLE;
						if (op_q == OPS_CHECK) begin
							compResult_q <= mismatch_q;
						end
						if (op_q == OPS_SECW) begin
							otpLocked_q <= 1'b1;
						end
					end
				end
				default: begin
					op_q <= OPS_IDLE;
				end
			endcase
		end
	end

	// buffers: security data from the fifo into buffer 1, page copies into either
	always_ff @(posedge clk) begin
		if (fifoOutValid && drainReady) begin
			bufMem[0][9'(fifoOutData[FIFO_WIDTH-1:8])] <= fifoOutData[7:0];
		end else if (op_q == OPS_COPY && !walkDone_q) begin
			bufMem[bufSel_q][idx_q] <= mainMem[memAddr];
		end
	end

	// user security part is written once, straight over its old content
	always_ff @(posedge clk) begin
		if (op_q == OPS_SECW && !walkDone_q && !otpLocked_q) begin
			secUser[idx_q[SEC_PTR_W-1:0]] <= bufMem[0][idx_q];
		end
	end

	// main memory preload port
	always_ff @(posedge clk) begin
		if (loadEn) begin
			mainMem[loadAddr] <= loadData;
		end
	end

	// byte to shift out in the current position of the frame
	assign secIdx = byteCnt_q - 9'(HDR_BYTES);
	assign statusByte = {!opBusy, compResult_q, STAT_DENSITY, STAT_PROTECT, binS_q[1]};
	always_comb begin
		txByte = UNDEF_BYTE;
		txActive = 1'b0;
		if (opcode_q == OP_STATUS && byteCnt_q != 9'h000) begin
			txActive = 1'b1;
			if (byteCnt_q[0]) begin
				txByte = statusByte;
			end else begin
				txByte = {!opBusy, 7'h00};
			end
		end else if (opcode_q == OP_SEC_READ && byteCnt_q >= 9'(HDR_BYTES)) begin
			txActive = 1'b1;
			if (secIdx < 9'(SEC_USER_BYTES)) begin
				txByte = secUser[secIdx[SEC_PTR_W-1:0]];
			end else if (secIdx < 9'(SEC_BYTES)) begin
				txByte = FACTORY_ID[{secIdx[SEC_PTR_W-1:0], 3'h0} +: 8];
			end else begin
				txByte = UNDEF_BYTE;
			end
		end
	end

	// serial output changes on falling clock edges, floats when deselected
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			so <= 1'b0;
			soOe <= 1'b0;
		end else if (csHigh) begin
			so <= 1'b0;
			soOe <= 1'b0;
		end else if (sckFall && txActive) begin
			so <= txByte[3'h7 - bitCnt_q];
			soOe <= 1'b1;
		end
	end

	// ready pin mirrors the status ready bit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			readyOut <= 1'b1;
		end else begin
			readyOut <= !opBusy;
		end
	end
endmodule : security_area_and_page_buffer_ops
`default_nettype wire

// File: verification/spi_host_model.sv
// host-side serial controller model: chip select, serial clock and data in
`default_nettype none
module spi_host_model (
	input wire logic clk, // system clock that paces the link
	output logic csn, // chip select, active low
	output logic sck, // serial clock, stands low between frames
	output logic si, // serial data to the device
	input wire logic soPin // resolved serial data from the device
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle levels at time zero
	initial begin
		csn = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// select the device, clock still idle
	task automatic frame_start();
		@(posedge clk);
		csn <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : frame_start
	// one byte msb first; data set while low, answer taken late in the high phase
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si <= tx[i];
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			repeat (4) @(posedge clk);
			rx[i] = soPin;
			sck <= 1'b0;
		end
	endtask : xfer
	// deselect; released data line shows the inverse of its last bit
	task automatic frame_end();
		repeat (4) @(posedge clk);
		csn <= 1'b1;
		si <= ~si;
		repeat (8) @(posedge clk);
	endtask : frame_end
endmodule : spi_host_model
`default_nettype wire

// File: verification/secarea_ops_sva.sv
// assertions on the serial pins and ready flag of the command logic
`default_nettype none
module secarea_ops_chk #(
	parameter int PAGES = 2048,
	parameter int PAGE_BYTES = 264,
	parameter int SECW_DUR = 5000,
	parameter int COPY_DUR = 2500,
	parameter int CHECK_DUR = 2500
) (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic csn, // chip select
	input wire logic sck, // serial clock
	input wire logic si, // serial data in
	input wire logic so, // serial data out
	input wire logic soOe, // output enable
	input wire logic binaryPage, // page size strap
	input wire logic readyOut, // ready flag
	input wire logic loadEn, // preload strobe
	input wire logic [$clog2(PAGES*PAGE_BYTES)-1:0] loadAddr, // preload address
	input wire logic [7:0] loadData // preload byte
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MIN_A = (COPY_DUR < CHECK_DUR) ? COPY_DUR : CHECK_DUR;
	localparam int MIN_BUSY = (SECW_DUR < MIN_A) ? SECW_DUR : MIN_A;
	localparam int MAX_BUSY = SECW_DUR + COPY_DUR + CHECK_DUR + PAGE_BYTES + 400;
	logic [15:0] busyLen_q;
	// length of the current busy period
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busyLen_q <= 16'h0000;
		end else begin
			busyLen_q <= readyOut ? 16'h0000 : busyLen_q + 16'h0001;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence frameDone;
		csn && !$past(csn, 6);
	endsequence
	a_float_after_cs: assert property (csn [*5] |-> !soOe) else $error("output driven after deselect");
	a_quiet_when_off: assert property (!soOe |-> !so) else $error("data out not low while undriven");
	a_drive_in_frame: assert property (soOe |-> !$past(csn, 4)) else $error("output driven outside a frame");
	a_busy_on_rise: assert property ($fell(readyOut) |-> frameDone) else $error("busy without a closed frame");
	a_busy_min_len: assert property ($rose(readyOut) |-> busyLen_q >= MIN_BUSY) else $error("busy too short");
	a_busy_max_len: assert property (busyLen_q <= MAX_BUSY) else $error("busy too long");
	a_ready_holds: assert property ($rose(readyOut) |=> readyOut [*8]) else $error("busy again without command");
	// data out only moves while the serial clock has been low for two samples
	property soAfterFall;
		$changed(so) && $past(soOe) |-> !sck && !$past(sck);
	endproperty
	a_so_on_fall: assert property (soAfterFall) else $error("so moved on rise");
endmodule : secarea_ops_chk
bind security_area_and_page_buffer_ops secarea_ops_chk #(.PAGES(PAGES), .PAGE_BYTES(PAGE_BYTES),
	.SECW_DUR(SECW_DUR), .COPY_DUR(COPY_DUR), .CHECK_DUR(CHECK_DUR)) i_secarea_ops_chk (.clk(clk),
	.resetn(resetn), .csn(csn), .sck(sck), .si(si), .so(so), .soOe(soOe), .binaryPage(binaryPage),
	.readyOut(readyOut), .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData));
`default_nettype wire

// File: verification/security_area_and_page_buffer_ops_tb_top.sv
// testbench for the security area and page buffer command logic
`default_nettype none
module security_area_and_page_buffer_ops_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import secarea_pkg::*;
	localparam int PG = 4;
	localparam logic [511:0] FID = {32{16'h3C96}}; // arbitrary value
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic binaryPage = 1'b0;
	logic loadEn = 1'b0;
	logic [10:0] loadAddr = 11'h000;
	logic [7:0] loadData = 8'h00;
	logic csn, sck, si, so, soOe, readyOut;
	logic [7:0] rx;
	logic [7:0] userExp [64];
	int errTotal = 0;
	int checkCount = 0;
	wire soPin = soOe ? so : ~so; // released line reads high: the inverse of so, which is low while undriven
	// 25 MHz clock
	always #20 clk = ~clk;
	security_area_and_page_buffer_ops #(.PAGES(PG), .SECW_DUR(900), .COPY_DUR(300), .CHECK_DUR(300),
		.FACTORY_ID(FID)) i_security_area_and_page_buffer_ops (.clk(clk), .resetn(resetn), .csn(csn),
		.sck(sck), .si(si), .so(so), .soOe(soOe), .binaryPage(binaryPage), .readyOut(readyOut),
		.loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData));
	spi_host_model i_spi_host_model (.clk(clk), .csn(csn), .sck(sck), .si(si), .soPin(soPin));
	task automatic check(input string what, input logic [7:0] expv, input logic [7:0] got);
		checkCount++;
		if (got !== expv) begin
			errTotal++;
			$display("Error %s expected %h seen %h", what, expv, got);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic send_hdr(input logic [7:0] op, input logic [23:0] addr);
		i_spi_host_model.frame_start();
		i_spi_host_model.xfer(op, rx);
		for (int i = 2; i >= 0; i--) begin
			i_spi_host_model.xfer(addr[8*i+:8], rx);
		end
	endtask : send_hdr
	task automatic wait_ready();
		int n;
		n = 0;
		while (readyOut !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check("ready", 8'h01, {7'h00, readyOut});
	endtask : wait_ready
	task automatic check_status(input logic rdy, input logic comp);
		i_spi_host_model.frame_start();
		i_spi_host_model.xfer(OP_STATUS, rx);
		for (int i = 0; i < 3; i++) begin
			i_spi_host_model.xfer(8'h00, rx);
			check("status", (i == 1) ? {rdy, 7'h00} : {rdy, comp, STAT_DENSITY, STAT_PROTECT, binaryPage}, rx);
		end
		i_spi_host_model.frame_end();
	endtask : check_status
	task automatic page_op(input logic [7:0] op, input logic [23:0] addr, input logic expComp);
		send_hdr(op, addr);
		i_spi_host_model.frame_end();
		check("busy", 8'h00, {7'h00, readyOut});
		wait_ready();
		check_status(1'b1, expComp);
	endtask : page_op
	task automatic sec_prog(input logic [7:0] base, input int n);
		send_hdr(OP_SEC_PROG, {3{SEC_PROG_ARG}});
		for (int k = 0; k < n; k++) begin
			i_spi_host_model.xfer(base + 8'(k), rx);
		end
		i_spi_host_model.frame_end();
		check("busy", 8'h00, {7'h00, readyOut});
	endtask : sec_prog
	task automatic sec_read();
		send_hdr(OP_SEC_READ, 24'h000000);
		for (int k = 0; k <= SEC_BYTES; k++) begin
			i_spi_host_model.xfer(8'h00, rx);
			check("secbyte", (k < 64) ? userExp[k] : (k < SEC_BYTES) ? FID[8*(k-64)+:8] : UNDEF_BYTE, rx);
		end
		i_spi_host_model.frame_end();
	endtask : sec_read
	// page 0 mirrors the programmed user part, page 2 differs in its last byte
	task automatic preload();
		for (int a = 0; a < PG*PAGE_BYTES_STD; a++) begin
			loadEn <= 1'b1;
			loadAddr <= 11'(a);
			loadData <= (a < 64) ? userExp[a] : (a == 2*PAGE_BYTES_STD + 263) ? 8'hFF : 8'(a % PAGE_BYTES_STD);
			@(posedge clk);
		end
		loadEn <= 1'b0;
	endtask : preload
	task automatic test_copy_compare();
		page_op(OP_XFER_B1, 24'h000200, 1'b0);
		page_op(OP_XFER_B2, 24'h000400, 1'b0);
		page_op(OP_CMP_B1, 24'h000400, 1'b1);
		page_op(OP_CMP_B2, 24'h000200, 1'b1);
		page_op(OP_CMP_B1, 24'h000600, 1'b0);
		page_op(OP_CMP_B2, 24'h000200, 1'b1);
		binaryPage <= 1'b1;
		page_op(OP_CMP_B2, 24'h000100, 1'b0);
		binaryPage <= 1'b0;
		$display("test copy compare done");
	endtask : test_copy_compare
	task automatic test_sec_prog();
		sec_prog(8'h40, 66);
		wait_ready();
		page_op(OP_CMP_B1, 24'h000400, 1'b1);
		page_op(OP_CMP_B1, 24'h000000, 1'b0);
		sec_read();
		$display("test security program done");
	endtask : test_sec_prog
	task automatic test_otp_lock();
		sec_prog(8'hC0, 64);
		send_hdr(OP_CMP_B2, 24'h000200);
		i_spi_host_model.frame_end();
		check_status(1'b0, 1'b0);
		wait_ready();
		check_status(1'b1, 1'b0);
		sec_read();
		$display("test lock done");
	endtask : test_otp_lock
	// main sequence
	initial begin
		for (int k = 0; k < 66; k++) begin
			userExp[k % 64] = 8'h40 + 8'(k);
		end
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		preload();
		check_status(1'b1, 1'b0);
		$display("test status done");
		test_copy_compare();
		test_sec_prog();
		test_otp_lock();
		end_of_test();
	end
	// watchdog
	initial begin
		repeat (100000) @(posedge clk);
		errTotal++;
		end_of_test();
	end
endmodule : security_area_and_page_buffer_ops_tb_top
`default_nettype wire
